// ===== rtl/sfs_supervisor.sv
// Purpose: timed supervisor for the on/off request, rail faults, power good
// Assumes: comparator results arrive asynchronously and are synchronised
// Notes: power-on reset is sys_rst_in; outputs are registered
// Operation
// - any fault drives fault-protect high, held by a latch
// - debounced request rising low to high clears the fault latch
// - both request edges debounced 38 ms before affecting fault-protect
// - undervoltage ignored by the fault latch for 75 ms after debounced request falls
// - turn-off adds 2.3 ms before fault-protect rises; none at turn-on
// - fault-protect low only when request low or inside the turn-off delay, and no fault latched
// - undervoltage on 3.3 V or 5 V beyond 146 us faults
// - overvoltage on 3.3 V, 5 V or 12 V beyond 73 us faults
// - latch stays until request toggles high or power-on reset
// - power good rises 300 ms or 150 ms after all inputs good
// - power good drops once a 150 us debounce of a bad input ends
module sfs_supervisor #(
  parameter bit PG_LONG = 1'b1,
  parameter int ON_DEBOUNCE = sfs_pkg::ON_DEBOUNCE_CYC,
  parameter int UV_BLANK = sfs_pkg::UV_BLANK_CYC,
  parameter int OFF_DELAY = sfs_pkg::OFF_DELAY_CYC,
  parameter int UV_GLITCH = sfs_pkg::UV_GLITCH_CYC,
  parameter int OV_GLITCH = sfs_pkg::OV_GLITCH_CYC,
  parameter int PG_DELAY_LONG = sfs_pkg::PG_DELAY_LONG_CYC,
  parameter int PG_DELAY_SHORT = sfs_pkg::PG_DELAY_SHORT_CYC,
  parameter int PG_DROP = sfs_pkg::PG_DROP_CYC
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic supply_on_request_n_in,
  input wire sfs_pkg::sfs_sense_type sense_in,
  output logic fault_protect_out_n_out,
  output logic power_good_out_out
);
  localparam int W = sfs_pkg::CNT_W;
  localparam int PGD = PG_LONG ? PG_DELAY_LONG : PG_DELAY_SHORT;
  localparam int LIM = 1 << W;

  // counts must fit the counter width and be at least one cycle
  if (ON_DEBOUNCE < 1 || UV_BLANK < 1 || OFF_DELAY < 1 || UV_GLITCH < 1 ||
      OV_GLITCH < 1 || PGD < 1 || PG_DROP < 1 || ON_DEBOUNCE >= LIM ||
      UV_BLANK >= LIM || OFF_DELAY >= LIM || UV_GLITCH >= LIM ||
      OV_GLITCH >= LIM || PGD >= LIM || PG_DROP >= LIM) begin : g_bad_count
    $error("sfs_supervisor: count parameter out of range");
  end

  sfs_pkg::sfs_state_type r;
  sfs_pkg::sfs_state_type next_r;

  // counter that climbs while its condition holds and restarts otherwise
  function automatic logic [W-1:0] bump(input logic cond,
                                        input logic [W-1:0] c,
                                        input int lim);
    if (!cond) return '0;
    if (c >= W'(lim)) return c;
    return c + W'(1);
  endfunction

  logic uv_any;
  logic ov_any;
  logic pg_bad;
  logic uv_hit;
  logic ov_hit;
  logic req_rise;
  logic req_fall;

  // next-state logic, all delays as clock counts
  always_comb begin
    next_r = r;
    next_r.s1 = sense_in;
    next_r.s2 = r.s1;
    next_r.req_s1 = supply_on_request_n_in;
    next_r.req_s2 = r.req_s1;
    // request debounce on both edges
    next_r.req_cnt = bump(r.req_s2 != r.req_db, r.req_cnt, ON_DEBOUNCE);
    req_rise = 1'b0;
    req_fall = 1'b0;
    if (r.req_s2 != r.req_db && r.req_cnt >= W'(ON_DEBOUNCE - 1)) begin
      next_r.req_db = r.req_s2;
      next_r.req_cnt = '0;
      req_rise = r.req_s2;
      req_fall = !r.req_s2;
    end
    // undervoltage blanking window after turn-on
    if (req_fall) begin
      next_r.blank_cnt = '0;
    end else if (!r.req_db && r.blank_cnt < W'(UV_BLANK)) begin
      next_r.blank_cnt = r.blank_cnt + W'(1);
    end
    uv_any = r.s2.uv_3v3 || r.s2.uv_5v;
    ov_any = r.s2.ov_3v3 || r.s2.ov_5v || r.s2.ov_12v;
    // deglitch of rail faults
    next_r.uv_cnt = bump(uv_any && !r.req_db &&
                         r.blank_cnt >= W'(UV_BLANK), r.uv_cnt, UV_GLITCH);
    next_r.ov_cnt = bump(ov_any, r.ov_cnt, OV_GLITCH);
    uv_hit = r.uv_cnt >= W'(UV_GLITCH);
    ov_hit = r.ov_cnt >= W'(OV_GLITCH);
    // fault latch: set wins, cleared by request rise only
    if (uv_hit || ov_hit) begin
      next_r.fault = 1'b1;
    end else if (req_rise) begin
      next_r.fault = 1'b0;
    end
    // turn-off delay counter
    next_r.off_cnt = bump(r.req_db, r.off_cnt, OFF_DELAY);
    // fault-protect output
    if (next_r.fault) begin
      next_r.fpo_n = 1'b1;
    end else if (!r.req_db && !req_rise) begin // no fault and request on turns rails on
      next_r.fpo_n = 1'b0;
    end else if (r.off_cnt >= W'(OFF_DELAY)) begin
      next_r.fpo_n = 1'b1;
    end
    // power good path
    pg_bad = !r.s2.pg_in_ok || uv_any;
    next_r.pg_cnt = bump(!pg_bad && !r.fault && !r.req_db, r.pg_cnt, PGD);
    next_r.drop_cnt = bump(pg_bad, r.drop_cnt, PG_DROP);
    if (r.fault || r.req_db || r.drop_cnt >= W'(PG_DROP)) begin
      next_r.pg = 1'b0;
    end else if (r.pg_cnt >= W'(PGD)) begin
      next_r.pg = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      r <= '0;
      r.req_s1 <= sfs_pkg::REQ_RST;
      r.req_s2 <= sfs_pkg::REQ_RST;
      r.req_db <= sfs_pkg::REQ_RST;
      r.fault <= sfs_pkg::LATCH_RST;
      r.fpo_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign fault_protect_out_n_out = r.fpo_n;
  assign power_good_out_out = r.pg;

  // fault latched forces fault-protect high next cycle
  property p_fault_fpo;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      r.fault |=> fault_protect_out_n_out;
  endproperty
  a_fault_fpo: assert property (p_fault_fpo)
    else $error("fault latched but fault-protect low");

  property p_clear;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (r.fault && !uv_hit && !ov_hit && req_rise) |=> !r.fault;
  endproperty
  a_clear: assert property (p_clear)
    else $error("request rise did not clear latch");

  property p_db;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      $changed(r.req_db) |-> $past(r.req_cnt) >= W'(ON_DEBOUNCE - 1);
  endproperty
  a_db: assert property (p_db)
    else $error("request changed before debounce");

  property p_blank;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (r.blank_cnt < W'(UV_BLANK)) |=> r.uv_cnt == '0;
  endproperty
  a_blank: assert property (p_blank)
    else $error("undervoltage counted during blanking");

  property p_off;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      ($rose(fault_protect_out_n_out) && !r.fault) |->
        $past(r.off_cnt) >= W'(OFF_DELAY);
  endproperty
  a_off: assert property (p_off)
    else $error("fault-protect rose before turn-off delay");

  // fault-protect low only while on, or inside the turn-off delay
  property p_on;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      !fault_protect_out_n_out |-> (!r.fault && (!$past(r.req_db) ||
        $past(r.off_cnt) < W'(OFF_DELAY)));
  endproperty
  a_on: assert property (p_on)
    else $error("fault-protect low while off or faulted");

  // fault-protect falls only while the debounced request is low
  property p_on_edge;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      $fell(fault_protect_out_n_out) |-> (!$past(r.req_db) &&
        !$past(req_rise));
  endproperty
  a_on_edge: assert property (p_on_edge)
    else $error("fault-protect fell at turn-off");

  // latch set, then fault-protect high and power good low a cycle later
  sequence s_trip;
    r.fault ##1 (fault_protect_out_n_out && !power_good_out_out);
  endsequence

  property p_uv;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      uv_hit |=> s_trip;
  endproperty
  a_uv: assert property (p_uv)
    else $error("undervoltage did not fault");

  property p_ov;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      ov_hit |=> s_trip;
  endproperty
  a_ov: assert property (p_ov)
    else $error("overvoltage did not fault");

  property p_hold;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      $fell(r.fault) |-> $past(req_rise);
  endproperty
  a_hold: assert property (p_hold)
    else $error("latch cleared without request rise");

  property p_pg;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      $rose(power_good_out_out) |-> $past(r.pg_cnt) >= W'(PGD);
  endproperty
  a_pg: assert property (p_pg)
    else $error("power good rose early");

  property p_drop;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (r.drop_cnt >= W'(PG_DROP)) |=> !power_good_out_out;
  endproperty
  a_drop: assert property (p_drop)
    else $error("power good not dropped");
endmodule

// ===== rtl/sfs_pkg.sv
// Purpose: shared constants and types for the supply fault supervisor
// Assumes: 200 MHz system clock
// Notes: times are kept in their printed unit, cycle counts derive from them
package sfs_pkg;
  localparam int CLK_MHZ = 200;
  localparam int CLK_PERIOD_PS = 1000000 / CLK_MHZ;
  // printed times
  localparam int ON_DEBOUNCE_MS = 38;
  localparam int UV_BLANK_MS = 75;
  localparam int OFF_DELAY_US = 2300;
  localparam int UV_GLITCH_US = 146;
  localparam int OV_GLITCH_US = 73;
  localparam int PG_DELAY_LONG_MS = 300;
  localparam int PG_DELAY_SHORT_MS = 150;
  localparam int PG_DROP_US = 150;
  // cycle counts (least times, whole cycles)
  localparam int ON_DEBOUNCE_CYC = ON_DEBOUNCE_MS * 1000 * CLK_MHZ;
  localparam int UV_BLANK_CYC = UV_BLANK_MS * 1000 * CLK_MHZ;
  localparam int OFF_DELAY_CYC = OFF_DELAY_US * CLK_MHZ;
  localparam int UV_GLITCH_CYC = UV_GLITCH_US * CLK_MHZ;
  localparam int OV_GLITCH_CYC = OV_GLITCH_US * CLK_MHZ;
  localparam int PG_DELAY_LONG_CYC = PG_DELAY_LONG_MS * 1000 * CLK_MHZ;
  localparam int PG_DELAY_SHORT_CYC = PG_DELAY_SHORT_MS * 1000 * CLK_MHZ;
  localparam int PG_DROP_CYC = PG_DROP_US * CLK_MHZ;
  localparam int CNT_W = 27;
  // reset values
  localparam logic REQ_RST = 1'b1;
  localparam logic LATCH_RST = 1'b0;

  // comparator results, high means condition present
  typedef struct packed {
    logic uv_3v3;
    logic uv_5v;
    logic ov_3v3;
    logic ov_5v;
    logic ov_12v;
    logic pg_in_ok;
  } sfs_sense_type;

  typedef struct packed {
    sfs_sense_type s1;
    sfs_sense_type s2;
    logic req_s1;
    logic req_s2;
    logic req_db;
    logic [CNT_W-1:0] req_cnt;
    logic [CNT_W-1:0] blank_cnt;
    logic [CNT_W-1:0] off_cnt;
    logic [CNT_W-1:0] uv_cnt;
    logic [CNT_W-1:0] ov_cnt;
    logic [CNT_W-1:0] pg_cnt;
    logic [CNT_W-1:0] drop_cnt;
    logic fault;
    logic fpo_n;
    logic pg;
  } sfs_state_type;
endpackage

// ===== testbench/sfs_host_model.sv
// Purpose: stand-in for the motherboard request and the rail comparators
// Assumes: the bench sets the wanted levels between rising edges
// Notes: outputs move only on rising edges; power is off at time zero
module sfs_host_model (
  input wire logic clk_sys_in,
  input wire logic want_on_in,
  input wire sfs_pkg::sfs_sense_type want_sense_in,
  output logic supply_on_request_n_out,
  output sfs_pkg::sfs_sense_type sense_out
);
  initial begin
    supply_on_request_n_out = 1'b1;
    sense_out = '0;
  end
  // request held low for as long as rail power is wanted
  always @(posedge clk_sys_in) begin
    supply_on_request_n_out <= ~want_on_in;
    sense_out <= want_sense_in;
  end
endmodule

// ===== testbench/sfs_supervisor_test.sv
// Purpose: self-checking bench for the supply fault supervisor
// Assumes: short cycle counts stand in for the long timebase figures
// Notes: outputs are sampled on falling edges, inputs move on rising ones
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
  failures++; $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); \
  end end
module sfs_supervisor_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DB = 20, OD = 5, UG = 4, OG = 3, PL = 40, PD = 4, PS = 20;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic want_on = 1'b0;
  sfs_pkg::sfs_sense_type want_sense = '0;
  logic req_n;
  sfs_pkg::sfs_sense_type sense;
  logic fpo_n;
  logic pg;
  logic pg_s;
  int failures = 0;
  int n_tests = 0;
  always #2.5 clk_sys_in = ~clk_sys_in;
  sfs_host_model host (.clk_sys_in(clk_sys_in), .want_on_in(want_on),
    .want_sense_in(want_sense), .supply_on_request_n_out(req_n),
    .sense_out(sense));
  sfs_supervisor #(.PG_LONG(1'b1), .ON_DEBOUNCE(DB), .UV_BLANK(30),
    .OFF_DELAY(OD), .UV_GLITCH(UG), .OV_GLITCH(OG), .PG_DELAY_LONG(PL),
    .PG_DELAY_SHORT(PS), .PG_DROP(PD)) dut (.clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in), .supply_on_request_n_in(req_n),
    .sense_in(sense), .fault_protect_out_n_out(fpo_n),
    .power_good_out_out(pg));
  // same supervisor with the short power-good delay
  sfs_supervisor #(.PG_LONG(1'b0), .ON_DEBOUNCE(DB), .UV_BLANK(30),
    .OFF_DELAY(OD), .UV_GLITCH(UG), .OV_GLITCH(OG), .PG_DELAY_LONG(PL),
    .PG_DELAY_SHORT(PS), .PG_DROP(PD)) dut_short (.clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in), .supply_on_request_n_in(req_n),
    .sense_in(sense), .fault_protect_out_n_out(),
    .power_good_out_out(pg_s));
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  // bounded wait for fault-protect (sel 0) or power good (sel 1)
  task automatic wait_lvl(input bit sel, input logic lvl, input int lim,
                          output int t);
    t = 0;
    while ((sel ? pg : fpo_n) !== lvl && t < lim) begin
      @(negedge clk_sys_in);
      t++;
    end
    if ((sel ? pg : fpo_n) !== lvl) begin
      failures++;
      $display("CHECK FAILED wait expected %0h seen timeout", lvl);
      print_verdict();
    end
  endtask
  // change the request and time the fault-protect answer
  task automatic set_on(input logic on, input int lo, input int hi);
    int t;
    @(posedge clk_sys_in);
    want_on <= on;
    wait_lvl(1'b0, ~on, hi, t);
    `CHK("request delay", 1'b1, t >= lo)
  endtask
  task automatic go_off();
    @(posedge clk_sys_in);
    want_on <= 1'b0;
    want_sense <= '0;
    step(DB + OD + 12);
  endtask
  task automatic t_turn_on();
    `CHK("fpo at reset", 1'b1, fpo_n)
    `CHK("pg at reset", 1'b0, pg)
    @(posedge clk_sys_in);
    want_on <= 1'b1;
    step(10);
    want_on <= 1'b0;
    step(40);
    `CHK("short request", 1'b1, fpo_n)
    set_on(1'b1, DB, DB + 10);
    want_sense.uv_3v3 <= 1'b1;
    step(10);
    want_sense.uv_3v3 <= 1'b0;
    step(2);
    `CHK("uv in blank", 1'b0, fpo_n)
    $display("test turn_on done");
  endtask
  task automatic t_power_good();
    int t;
    want_sense.pg_in_ok <= 1'b1;
    step(PS - 2);
    `CHK("short pg early", 1'b0, pg_s)
    step(PL - PS);
    `CHK("short pg", 1'b1, pg_s)
    `CHK("pg early", 1'b0, pg)
    wait_lvl(1'b1, 1'b1, 20, t);
    want_sense.pg_in_ok <= 1'b0;
    step(2);
    want_sense.pg_in_ok <= 1'b1;
    step(8);
    `CHK("pg glitch", 1'b1, pg)
    want_sense.pg_in_ok <= 1'b0;
    wait_lvl(1'b1, 1'b0, PD + 8, t);
    `CHK("pg drop time", 1'b1, t >= PD)
    `CHK("fpo after pg drop", 1'b0, fpo_n)
    want_sense.pg_in_ok <= 1'b1;
    $display("test power_good done");
  endtask
  task automatic t_undervoltage();
    int t;
    want_sense.uv_5v <= 1'b1;
    step(2);
    want_sense.uv_5v <= 1'b0;
    step(10);
    `CHK("uv glitch", 1'b0, fpo_n)
    wait_lvl(1'b1, 1'b1, PL + 10, t);
    want_sense.uv_5v <= 1'b1;
    wait_lvl(1'b0, 1'b1, UG + 8, t);
    `CHK("uv time", 1'b1, t >= UG)
    step(2);
    `CHK("pg on uv", 1'b0, pg)
    want_sense.uv_5v <= 1'b0;
    step(20);
    `CHK("latch holds", 1'b1, fpo_n)
    go_off();
    set_on(1'b1, DB, DB + 10);
    set_on(1'b0, DB + OD, DB + OD + 12);
    $display("test undervoltage done");
  endtask
  task automatic t_overvoltage();
    int t;
    for (int i = 0; i < 3; i++) begin
      set_on(1'b1, DB, DB + 10);
      want_sense[3-i] <= 1'b1;
      wait_lvl(1'b0, 1'b1, OG + 8, t);
      `CHK("ov time", 1'b1, t >= OG)
      want_sense[3-i] <= 1'b0;
      step(10);
      `CHK("ov latch", 1'b1, fpo_n)
      go_off();
    end
    $display("test overvoltage done");
  endtask
  // pulse power-on reset, then time the re-debounced turn-on
  task automatic por_pulse();
    int t;
    @(posedge clk_sys_in);
    sys_rst_in <= 1'b1;
    step(2);
    `CHK("fpo in reset", 1'b1, fpo_n)
    `CHK("pg in reset", 1'b0, pg)
    @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    wait_lvl(1'b0, 1'b0, DB + 10, t);
    `CHK("reset debounce", 1'b1, t >= DB)
  endtask
  // power-on reset mid-run raises fault-protect, drops power good and clears a latched fault
  task automatic t_por();
    int t;
    set_on(1'b1, DB, DB + 10);
    want_sense.pg_in_ok <= 1'b1;
    wait_lvl(1'b1, 1'b1, PL + 10, t);
    por_pulse();
    want_sense.ov_12v <= 1'b1;
    wait_lvl(1'b0, 1'b1, OG + 8, t);
    want_sense.ov_12v <= 1'b0;
    por_pulse();
    go_off();
    $display("test power_on_reset done");
  endtask
  initial begin
    repeat (6) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    step(2);
    t_turn_on();
    t_power_good();
    t_undervoltage();
    t_overvoltage();
    t_por();
    print_verdict();
  end
endmodule
